// *** hdl/sync_pll_pkg.sv ***
/*
  Constants, register map and carrier types of the sync lock supervisor.
  Assumes a 100 MHz system clock and a plain single-cycle register port.
*/
// Operation
// - Lock only to falling sync edges
// - Phase offset from low three config bits
// - Edge-triggered compare, no harmonic lock
// - Lock held across 200 kHz to 1 MHz
// - Lock loss sets status bit 4, alert
// - Fault clears only on written one
// - Masked fault sets flag, no alert
// - No sync edges: run nominal frequency
// - Pad bit 10 low while sync idle
// - Skip cycles below minimum on-time
package sync_pll_pkg;
  localparam int unsigned clock_hz = 100_000_000;
  localparam int unsigned addr_w = 4;
  localparam int unsigned data_w = 16;
  // Register indices on the command port
  localparam logic [3:0] reg_pwm_phase_config = 4'h0;
  localparam logic [3:0] reg_vendor_status_word = 4'h1;
  localparam logic [3:0] reg_alert_mask = 4'h2;
  localparam logic [3:0] reg_pad_state_register = 4'h3;
  localparam logic [3:0] reg_nominal_period = 4'h4;
  localparam logic [3:0] reg_duty_on_time = 4'h5;
  // Field positions
  localparam int unsigned phase_lsb = 0;
  localparam int unsigned phase_w = 3;
  localparam int unsigned sync_out_en_bit = 3;
  localparam int unsigned lock_fault_bit = 4;
  localparam int unsigned sync_idle_bit = 10;
  localparam int unsigned locked_bit = 0;
  // Timing
  localparam int unsigned min_on_ns = 60;
  localparam int unsigned max_min_on_ns = 90;
  localparam int unsigned min_on_cycles = (min_on_ns * (clock_hz / 1_000_000) + 999) / 1000;
  localparam int unsigned max_min_on_cycles =
    (max_min_on_ns * (clock_hz / 1_000_000) + 999) / 1000;
  localparam int unsigned sync_low_ns = 500;
  localparam int unsigned sync_low_cycles = (sync_low_ns * (clock_hz / 1_000_000)) / 1000;
  localparam int unsigned idle_periods = 4;
  localparam int unsigned lock_tol_div = 8;
  localparam int unsigned lock_good_count = 4;
  // 500 kHz nominal at reset
  localparam logic [15:0] nominal_period_reset = 16'h00c8;
  localparam logic [15:0] duty_on_reset = 16'h0050;
  localparam logic [15:0] phase_config_reset = 16'h0000;
  localparam logic [15:0] mask_reset = 16'h0000;

  typedef struct packed {
    logic [addr_w-1:0] addr;
    logic [data_w-1:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic top_gate;
    logic bottom_gate;
  } gate_drive_t;
endpackage

// *** hdl/sync_pll_lock_supervisor.sv ***
/*
  Sync-line tracking, phase placement and lock supervision of one
  switching channel. Assumes the sync line is open drain with a pull-up,
  sampled here as a foreign signal, and a master that never waits.
*/
`timescale 1ns/1ps
module sync_pll_lock_supervisor
  import sync_pll_pkg::*;
#(
  parameter int unsigned period_w = 16
)
(
  input wire logic clock,
  input wire logic reset,
  input wire sync_pll_pkg::reg_req_t req,
  output logic [sync_pll_pkg::data_w-1:0] rdata,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic alert_n,
  output logic alert_oe,
  output logic irq,
  output sync_pll_pkg::gate_drive_t gate,
  output logic skip_cycle
);
  import sync_pll_pkg::*;

  logic [data_w-1:0] phase_config;
  logic [data_w-1:0] alert_mask;
  logic [data_w-1:0] nominal_period;
  logic [data_w-1:0] duty_on;
  logic [data_w-1:0] status;
  logic sync_meta;
  logic sync_s;
  logic sync_d;
  logic fall_edge;
  logic [period_w-1:0] ref_count;
  logic [period_w-1:0] ref_period;
  logic [period_w-1:0] idle_count;
  logic sync_idle;
  logic [2:0] good_count;
  logic locked;
  logic was_locked;
  logic lost_lock;
  logic [period_w-1:0] osc_count;
  logic [period_w-1:0] active_period;
  logic [period_w-1:0] phase_target;
  logic [period_w-1:0] on_width;
  logic [period_w-1:0] drive_out_count;
  logic [period_w-1:0] sync_low_count;
  logic cycle_start;
  logic [period_w-1:0] next_osc_count;
  logic [data_w-1:0] pad_word;

  function automatic logic in_tolerance(input logic [period_w-1:0] a,
                                        input logic [period_w-1:0] b);
    logic [period_w-1:0] diff;
    diff = (a > b) ? a - b : b - a;
    return diff <= (b / period_w'(lock_tol_div));
  endfunction

  // Two-stage sampling of the shared sync line
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sync_meta <= 1'b1;
      sync_s <= 1'b1;
      sync_d <= 1'b1;
    end
    else
    begin
      sync_meta <= sync_in;
      sync_s <= sync_meta;
      sync_d <= sync_s;
    end
  end

  assign fall_edge = sync_d & ~sync_s;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ref_count <= '0;
      ref_period <= '0;
    end
    else if (fall_edge)
    begin
      ref_count <= period_w'(1);
      ref_period <= ref_count;
    end
    else if (ref_count != '1)
    begin
      ref_count <= ref_count + period_w'(1);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      idle_count <= '0;
      sync_idle <= 1'b1;
    end
    else if (fall_edge)
    begin
      idle_count <= '0;
      sync_idle <= 1'b0;
    end
    else if (idle_count >= period_w'(nominal_period * idle_periods))
    begin
      sync_idle <= 1'b1;
    end
    else
    begin
      idle_count <= idle_count + period_w'(1);
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      good_count <= '0;
      locked <= 1'b0;
    end
    else if (sync_idle)
    begin
      good_count <= '0;
      locked <= 1'b0;
    end
    else if (fall_edge)
    begin
      if (ref_period != '0 && in_tolerance(ref_count, ref_period))
      begin
        if (good_count == 3'(lock_good_count))
          locked <= 1'b1;
        else
          good_count <= good_count + 3'd1;
      end
      else
      begin
        good_count <= '0;
        locked <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      was_locked <= 1'b0;
    else
      was_locked <= locked;
  end

  // falling out of lock is the event
  assign lost_lock = was_locked & ~locked;

  assign active_period = (sync_idle || !locked) ? nominal_period : ref_period;

  // phase offset in eighths of a period
  assign phase_target = period_w'((32'(active_period) *
    32'(phase_config[phase_lsb +: phase_w])) >> 3);

  assign next_osc_count = (osc_count + period_w'(1) >= active_period) ? '0 :
    osc_count + period_w'(1);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      osc_count <= '0;
    else if (locked && fall_edge)
      osc_count <= '0;
    else
      osc_count <= next_osc_count;
  end

  assign cycle_start = (osc_count == phase_target);

  // skip cycles shorter than minimum on-time
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      on_width <= '0;
      skip_cycle <= 1'b0;
      gate <= '0;
    end
    else
    begin
      if (cycle_start)
      begin
        skip_cycle <= duty_on < data_w'(min_on_cycles);
        on_width <= (duty_on < data_w'(min_on_cycles)) ? '0 : duty_on;
      end
      else if (on_width != '0)
      begin
        on_width <= on_width - period_w'(1);
      end
      gate.top_gate <= (cycle_start && duty_on >= data_w'(min_on_cycles)) ||
        (!cycle_start && on_width > period_w'(1));
      gate.bottom_gate <= !((cycle_start && duty_on >= data_w'(min_on_cycles)) ||
        (!cycle_start && on_width > period_w'(1)));
    end
  end

  // Sync output pulls low a fixed time once per period
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      drive_out_count <= '0;
      sync_low_count <= '0;
      sync_oe <= 1'b0;
    end
    else
    begin
      drive_out_count <= (drive_out_count + period_w'(1) >= nominal_period) ? '0 :
        drive_out_count + period_w'(1);
      if (drive_out_count == '0 && phase_config[sync_out_en_bit])
        sync_low_count <= period_w'(sync_low_cycles);
      else if (sync_low_count != '0)
        sync_low_count <= sync_low_count - period_w'(1);
      sync_oe <= phase_config[sync_out_en_bit] &&
        (drive_out_count == '0 || sync_low_count > period_w'(1));
    end
  end

  assign sync_out = 1'b0;

  // Registers written by software
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      phase_config <= phase_config_reset;
      alert_mask <= mask_reset;
      nominal_period <= nominal_period_reset;
      duty_on <= duty_on_reset;
    end
    else if (req.write)
    begin
      unique case (req.addr)
        reg_pwm_phase_config: phase_config <= req.wdata;
        reg_alert_mask: alert_mask <= req.wdata;
        reg_nominal_period: nominal_period <= req.wdata;
        reg_duty_on_time: duty_on <= req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      status <= '0;
    else
    begin
      if (req.write && req.addr == reg_vendor_status_word)
        status <= status & ~req.wdata;
      if (lost_lock)
        status[lock_fault_bit] <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      alert_oe <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      alert_oe <= |(status & ~alert_mask);
      irq <= |(status & ~alert_mask);
    end
  end

  // alert is open drain, pulled low
  assign alert_n = 1'b0;

  always_comb
  begin
    pad_word = '0;
    pad_word[sync_idle_bit] = ~sync_idle;
    pad_word[locked_bit] = locked;
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      rdata <= '0;
    else if (req.read)
    begin
      unique case (req.addr)
        reg_pwm_phase_config: rdata <= phase_config;
        reg_vendor_status_word: rdata <= status;
        reg_alert_mask: rdata <= alert_mask;
        // bit 10 low while sync idle
        reg_pad_state_register: rdata <= pad_word;
        reg_nominal_period: rdata <= nominal_period;
        reg_duty_on_time: rdata <= duty_on;
        default: rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end
endmodule

// *** tb/sync_pll_lock_supervisor_properties.sv ***
/* Port assertions of the sync supervisor.
   Bound from the bench top; one clock domain. */
`timescale 1ns/1ps
module sync_pll_lock_supervisor_properties
  import sync_pll_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire sync_pll_pkg::reg_req_t req,
  input wire logic [sync_pll_pkg::data_w-1:0] rdata,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic alert_n,
  input wire logic alert_oe,
  input wire logic irq,
  input wire sync_pll_pkg::gate_drive_t gate
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence pull_held;
    sync_oe [*8];
  endsequence
  sequence top_on;
    gate.top_gate [*6];
  endsequence
  alert_pin_a: assert property (!alert_n && !sync_out)
    else $error("open-drain data not low");
  irq_alert_a: assert property (irq == alert_oe)
    else $error("irq differs from alert");
  fault_sticky_a: assert property (alert_oe && !req.write && !$past(req.write) |=> alert_oe)
    else $error("alert dropped without a write");
  idle_rdata_a: assert property (!$past(req.read) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
  unmapped_a: assert property ($past(req.read) && $past(req.addr) > 4'h5 |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  gate_comp_a: assert property (!$past(reset) |-> gate.top_gate != gate.bottom_gate)
    else $error("gate drive not complementary");
  min_on_a: assert property ($rose(gate.top_gate) |-> top_on)
    else $error("top gate pulse too short");
  sync_pulse_a: assert property ($rose(sync_oe) |-> pull_held ##[37:47] !sync_oe)
    else $error("sync pull length wrong");
endmodule

// *** tb/sync_line_source.sv ***
/* Clock source sharing the open-drain sync line.
   Assumes a pull-up; the bench combines all pulls. */
`timescale 1ns/1ps
module sync_line_source
(
  input wire logic run,
  input wire logic [15:0] period_ns,
  output logic pull
);
  initial pull = 1'b0;
  always
  begin
    if (run)
    begin
      pull = 1'b1;
      #(period_ns / 4);
      pull = 1'b0;
      #(period_ns - period_ns / 4);
    end
    else
      #10;
  end
endmodule

// *** tb/test_sync_pll_lock_supervisor.sv ***
/* Self-checking bench of the sync supervisor.
   Assumes the package map and a pulled-up sync line. */
`timescale 1ns/1ps
module test_sync_pll_lock_supervisor;
  import sync_pll_pkg::*;
  logic clock, reset, pull, run, sync_out, sync_oe, alert_n, alert_oe, irq, skip_cycle;
  logic [15:0] period_ns, rdata, m;
  reg_req_t req;
  gate_drive_t gate;
  logic [15:0] exp_q[$], msk_q[$];
  int num_errors, checks, seed, p;
  time t0;
  wire sync_in = !(pull || sync_oe);
  sync_pll_lock_supervisor dut_u (.clock(clock), .reset(reset), .req(req), .rdata(rdata),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe), .alert_n(alert_n),
    .alert_oe(alert_oe), .irq(irq), .gate(gate), .skip_cycle(skip_cycle));
  sync_line_source src_u (.run(run), .period_ns(period_ns), .pull(pull));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = !clock;
  end
  task cmp(input logic [15:0] a, input logic [15:0] e);
    checks++;
    if (a !== e)
    begin
      num_errors++;
      $display("unexpected %0t got %h want %h", $time, a, e);
    end
  endtask
  task conclude;
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Idle cycle after each strobe keeps one assignment per step
  task wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    req.write <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] mk);
    exp_q.push_back(e);
    msk_q.push_back(mk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    req.read <= 1'b0;
    @(posedge clock);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  always @(posedge clock)
    if (req.read && !reset)
    begin
      @(negedge clock);
      m = msk_q.pop_front();
      cmp(rdata & m, exp_q.pop_front() & m);
    end
  initial
  begin
    #400us;
    num_errors++;
    conclude();
  end
  initial
  begin
    seed = 50;
    reset = 1'b1;
    run = 1'b0;
    period_ns = 16'd2000;
    req = '0;
    idle(8);
    reset <= 1'b0;
    idle(1);
    rd(reg_pad_state_register, 16'h0000, 16'h0401);
    rd(reg_nominal_period, nominal_period_reset, 16'hffff);
    rd(4'hf, 16'h0000, 16'hffff);
    wr(4'he, 16'h1234);
    rd(4'he, 16'h0000, 16'hffff);
    p = $random(seed) & 7;
    wr(reg_pwm_phase_config, 16'(p));
    rd(reg_pwm_phase_config, 16'(p), 16'h000f);
    run <= 1'b1;
    idle(2000);
    rd(reg_pad_state_register, 16'h0401, 16'h0401);
    @(negedge sync_in);
    t0 = $time;
    @(posedge gate.top_gate);
    cmp(16'(((($time - t0) % 2000) + 60) / 250 % 8), 16'(p));
    run <= 1'b0;
    idle(1100);
    rd(reg_pad_state_register, 16'h0000, 16'h0401);
    rd(reg_vendor_status_word, 16'h0010, 16'h0010);
    cmp(16'(alert_oe), 16'h0001);
    @(posedge gate.top_gate);
    t0 = $time;
    @(posedge gate.top_gate);
    cmp(16'($time - t0), 16'd2000);
    run <= 1'b1;
    idle(2000);
    wr(reg_vendor_status_word, 16'h0000);
    rd(reg_vendor_status_word, 16'h0010, 16'h0010);
    wr(reg_vendor_status_word, 16'h0010);
    rd(reg_vendor_status_word, 16'h0000, 16'h0010);
    cmp(16'(alert_oe), 16'h0000);
    wr(reg_alert_mask, 16'h0010);
    run <= 1'b0;
    idle(1100);
    rd(reg_vendor_status_word, 16'h0010, 16'h0010);
    cmp(16'(irq), 16'h0000);
    wr(reg_alert_mask, 16'h0000);
    idle(3);
    cmp(16'(irq), 16'h0001);
    period_ns <= 16'd80;
    run <= 1'b1;
    idle(2000);
    rd(reg_pad_state_register, 16'h0400, 16'h0400);
    run <= 1'b0;
    idle(1100);
    wr(reg_pwm_phase_config, 16'h0008);
    idle(1000);
    rd(reg_pad_state_register, 16'h0400, 16'h0400);
    wr(reg_duty_on_time, 16'(min_on_cycles - 1));
    repeat (400) if (!skip_cycle) @(posedge clock);
    cmp(16'(skip_cycle), 16'h0001);
    conclude();
  end
endmodule
bind sync_pll_lock_supervisor sync_pll_lock_supervisor_properties chk_u (.clock(clock),
  .reset(reset), .req(req), .rdata(rdata), .sync_out(sync_out), .sync_oe(sync_oe),
  .alert_n(alert_n), .alert_oe(alert_oe), .irq(irq), .gate(gate));
